// ### verilog/pfp_regs.vh
`ifndef PFP_REGS_VH
`define PFP_REGS_VH

// register byte offsets
`define PFP_OFS_MASK      24'hffe384
`define PFP_OFS_STAT      24'hffe385
`define PFP_OFS_CTL       24'hffe388
`define PFP_ADDR_W        24

// fault_source_mask fields
`define PFP_FM_PIN        0
`define PFP_FM_CMP        1
`define PFP_FM_F1         2
`define PFP_FM_DBG        5
`define PFP_FM_WMASK      8'h27
`define PFP_FM_RESET      8'h00

// fault_status_flags fields
`define PFP_FS_PIN        0
`define PFP_FS_CMP        1
`define PFP_FS_F1         2
`define PFP_FS_DBG        5
`define PFP_FS_RLD        7
`define PFP_FS_FAULTS     8'h27
`define PFP_FS_RESET      8'h00

// fault_recovery_control fields
`define PFP_FC_PIN_RST    0
`define PFP_FC_PIN_INT    1
`define PFP_FC_CMPA_RST   2
`define PFP_FC_CMPA_INT   3
`define PFP_FC_CMPB_RST   4
`define PFP_FC_CMPB_INT   5
`define PFP_FC_DBG_RST    6
`define PFP_FC_WMASK      8'h7f
`define PFP_FC_RESET      8'h00

// reload rate select codes
`define PFP_RLD_W         2
`define PFP_RLD_CNT_W     3
`define PFP_RLD_CNT_ZERO  3'h0
`define PFP_RLD_DIV1      2'h0
`define PFP_RLD_DIV2      2'h1
`define PFP_RLD_DIV4      2'h2
`define PFP_RLD_DIV8      2'h3
`define PFP_RLD_LAST1     3'h0
`define PFP_RLD_LAST2     3'h1
`define PFP_RLD_LAST4     3'h3
`define PFP_RLD_LAST8     3'h7

// output block
`define PFP_NOUT          6
`define PFP_OUT_ZERO      6'h00
`define PFP_BYTE_ZERO     8'h00

`endif

// ### verilog/pfp_flag.v
`timescale 1ns/1ps
`default_nettype none

// one sticky fault flag: set wins, clear only when source gone
module pfp_flag
(
   input  wire clk,
   input  wire rst,
   input  wire set_in,
   input  wire clr_in,
   input  wire src_act,
   output reg  flag_r
);

   always @(posedge clk or posedge rst)
   begin
      if (rst)
         flag_r <= 1'b0;
      else if (set_in)
         flag_r <= 1'b1;
      else if (clr_in && !src_act)
         flag_r <= 1'b0;
   end

endmodule // pfp_flag

`default_nettype wire

// ### verilog/pfp_fault_protect.v
`timescale 1ns/1ps
`default_nettype none
`include "pfp_regs.vh"

//Function
// - mask bits only settable by writes
// - mask and control writes need modulator disabled
// - debug entry faults unless mask bit 5
// - second fault input faults unless bit 2
// - comparator faults unless mask bit 1
// - fault pin faults unless mask bit 0
// - masked source never sets its flag, except the debug flag
// - reload flag latches on every reload
// - debug flag latches on debug entry
// - second fault flag latches when unmasked
// - comparator flag latches when unmasked
// - primary fault flag latches when unmasked
// - write one clears flag, zero keeps
// - fault flag clears only after source deasserts
// - automatic recovery at next period start
// - software recovery needs clear flags, reload
// - interrupt enables gate pin and per-comparator flag interrupts; comparator edge pulse passes on either comparator enable
// - comparators fault and raise system exception
// - fault forces all six outputs off
// - reload every 1, 2, 4, 8 periods
module pfp_fault_protect
(
   input  wire                   clk,
   input  wire                   rst,
   input  wire [`PFP_ADDR_W-1:0] reg_addr,
   input  wire [7:0]             reg_wdata,
   input  wire                   reg_wr,
   input  wire                   reg_rd,
   output reg  [7:0]             reg_rdata,
   input  wire                   modulator_enable,
   input  wire [1:0]             reload_rate_select,
   input  wire                   period_end,
   input  wire                   fault_pin,
   input  wire                   second_fault_in,
   input  wire                   comparator_a,
   input  wire                   comparator_b,
   input  wire                   debug_mode,
   input  wire [`PFP_NOUT-1:0]   pwm_in,
   input  wire [`PFP_NOUT-1:0]   off_state,
   output reg  [`PFP_NOUT-1:0]   pwm_out,
   output wire                   pwm_owned,
   output wire                   fault_active,
   output wire                   reload_event,
   output wire                   fault_irq,
   output wire                   comparator_exception
);

   // output ownership states
   localparam ST_RUN  = 2'h0;
   localparam ST_AUTO = 2'h1;
   localparam ST_SOFT = 2'h2;

   reg  [7:0]                fault_source_mask_r;
   reg  [7:0]                fault_recovery_control_r;
   reg                       reload_seen_flag_r;
   reg                       debug_prev_r;
   reg  [`PFP_RLD_CNT_W-1:0] period_cnt_r;
   reg  [`PFP_RLD_CNT_W-1:0] period_last;
   reg  [1:0]                own_state_r;
   reg  [1:0]                own_state_nxt;
   reg                       cmp_prev_r;
   reg                       cmp_event_r;
   reg                       cmpa_seen_r;
   reg                       cmpb_seen_r;
   wire                      debug_entry;
   wire                      sel_mask;
   wire                      sel_stat;
   wire                      sel_ctl;
   wire                      stat_wr;
   wire                      src_pin;
   wire                      src_cmp;
   wire                      src_f1;
   wire                      src_dbg;
   wire                      primary_fault_flag;
   wire                      comparator_flag;
   wire                      second_fault_flag;
   wire                      debug_entry_flag;
   wire [7:0]                fault_status_flags;
   wire                      any_flag;
   wire                      sw_mode;
   wire                      cmp_any;
   wire                      irq_pin;
   wire                      irq_cmpa;
   wire                      irq_cmpb;

   assign sel_mask = (reg_addr == `PFP_OFS_MASK);
   assign sel_stat = (reg_addr == `PFP_OFS_STAT);
   assign sel_ctl  = (reg_addr == `PFP_OFS_CTL);
   assign stat_wr  = reg_wr && sel_stat;

   assign debug_entry = debug_mode && !debug_prev_r;
   assign cmp_any     = comparator_a | comparator_b;

   // source qualified by its mask bit
   assign src_pin = fault_pin &
                    ~fault_source_mask_r[`PFP_FM_PIN];
   assign src_cmp = cmp_any &
                    ~fault_source_mask_r[`PFP_FM_CMP];
   assign src_f1  = second_fault_in &
                    ~fault_source_mask_r[`PFP_FM_F1];
   assign src_dbg = debug_mode &
                    ~fault_source_mask_r[`PFP_FM_DBG];

   assign fault_active = src_pin | src_cmp | src_f1 | src_dbg;
   assign comparator_exception = cmp_any;

   // mask: set-only, locked while modulator runs
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         fault_source_mask_r <= `PFP_FM_RESET;
      else if (reg_wr && sel_mask && !modulator_enable)
         fault_source_mask_r <= fault_source_mask_r |
                                (reg_wdata & `PFP_FM_WMASK);
   end

   always @(posedge clk or posedge rst)
   begin
      if (rst)
         fault_recovery_control_r <= `PFP_FC_RESET;
      else if (reg_wr && sel_ctl && !modulator_enable)
         fault_recovery_control_r <= reg_wdata & `PFP_FC_WMASK;
   end

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         debug_prev_r <= 1'b0;
         cmp_prev_r   <= 1'b0;
      end
      else
      begin
         debug_prev_r <= debug_mode;
         cmp_prev_r   <= cmp_any;
      end
   end

   // flags: set only by unmasked sources, debug flag by any debug entry
   pfp_flag u_flag_pin
   (
      .clk     (clk),
      .rst     (rst),
      .set_in  (src_pin),
      .clr_in  (stat_wr && reg_wdata[`PFP_FS_PIN]),
      .src_act (fault_pin),
      .flag_r  (primary_fault_flag)
   );

   pfp_flag u_flag_cmp
   (
      .clk     (clk),
      .rst     (rst),
      .set_in  (src_cmp),
      .clr_in  (stat_wr && reg_wdata[`PFP_FS_CMP]),
      .src_act (cmp_any),
      .flag_r  (comparator_flag)
   );

   pfp_flag u_flag_f1
   (
      .clk     (clk),
      .rst     (rst),
      .set_in  (src_f1),
      .clr_in  (stat_wr && reg_wdata[`PFP_FS_F1]),
      .src_act (second_fault_in),
      .flag_r  (second_fault_flag)
   );

   pfp_flag u_flag_dbg
   (
      .clk     (clk),
      .rst     (rst),
      .set_in  (debug_entry),
      .clr_in  (stat_wr && reg_wdata[`PFP_FS_DBG]),
      .src_act (debug_mode),
      .flag_r  (debug_entry_flag)
   );

   // reload divider
   always @*
   begin
      case (reload_rate_select)
         `PFP_RLD_DIV1: period_last = `PFP_RLD_LAST1;
         `PFP_RLD_DIV2: period_last = `PFP_RLD_LAST2;
         `PFP_RLD_DIV4: period_last = `PFP_RLD_LAST4;
         `PFP_RLD_DIV8: period_last = `PFP_RLD_LAST8;
         default:       period_last = `PFP_RLD_LAST1;
      endcase
   end

   assign reload_event = period_end && modulator_enable &&
                         (period_cnt_r >= period_last);

   always @(posedge clk or posedge rst)
   begin
      if (rst)
         period_cnt_r <= `PFP_RLD_CNT_ZERO;
      else if (!modulator_enable)
         period_cnt_r <= `PFP_RLD_CNT_ZERO;
      else if (reload_event)
         period_cnt_r <= `PFP_RLD_CNT_ZERO;
      else if (period_end)
         period_cnt_r <= period_cnt_r + 1'b1;
   end

   always @(posedge clk or posedge rst)
   begin
      if (rst)
         reload_seen_flag_r <= 1'b0;
      else if (reload_event)
         reload_seen_flag_r <= 1'b1;
      else if (stat_wr && reg_wdata[`PFP_FS_RLD])
         reload_seen_flag_r <= 1'b0;
   end

   assign fault_status_flags = {reload_seen_flag_r, 1'b0,
                                debug_entry_flag, 2'b00,
                                second_fault_flag, comparator_flag,
                                primary_fault_flag};
   assign any_flag = |(fault_status_flags & `PFP_FS_FAULTS);

   // software recovery if any tripping source asks for it
   assign sw_mode =
      (src_dbg & fault_recovery_control_r[`PFP_FC_DBG_RST]) |
      (src_cmp & (fault_recovery_control_r[`PFP_FC_CMPA_RST] |
                  fault_recovery_control_r[`PFP_FC_CMPB_RST])) |
      ((src_pin | src_f1) & fault_recovery_control_r[`PFP_FC_PIN_RST]);

   // output ownership: run, automatic or software recovery
   always @*
   begin
      own_state_nxt = own_state_r;
      case (own_state_r)
         ST_RUN:
         begin
            if (fault_active)
               own_state_nxt = sw_mode ? ST_SOFT : ST_AUTO;
         end
         ST_AUTO:
         begin
            if (fault_active && sw_mode)
               own_state_nxt = ST_SOFT;
            else if (!fault_active && period_end)
               own_state_nxt = ST_RUN;
         end
         ST_SOFT:
         begin
            if (!fault_active && !any_flag && reload_event)
               own_state_nxt = ST_RUN;
         end
         default:
            own_state_nxt = ST_RUN;
      endcase
   end

   always @(posedge clk or posedge rst)
   begin
      if (rst)
         own_state_r <= ST_RUN;
      else
         own_state_r <= own_state_nxt;
   end

   assign pwm_owned = !fault_active && (own_state_r == ST_RUN);

   always @(posedge clk or posedge rst)
   begin
      if (rst)
         pwm_out <= `PFP_OUT_ZERO;
      else if (pwm_owned)
         pwm_out <= pwm_in;
      else
         pwm_out <= off_state;
   end

   // interrupt request while enabled source flag set, plus comparator rising-edge pulse
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         cmp_event_r <= 1'b0;
      else
         cmp_event_r <= cmp_any && !cmp_prev_r;
   end

   // which comparator set the shared flag, kept while flag set
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cmpa_seen_r <= 1'b0;
         cmpb_seen_r <= 1'b0;
      end
      else
      begin
         cmpa_seen_r <= (src_cmp & comparator_a) |
                        (cmpa_seen_r & comparator_flag);
         cmpb_seen_r <= (src_cmp & comparator_b) |
                        (cmpb_seen_r & comparator_flag);
      end
   end

   assign irq_pin  = primary_fault_flag &
                     fault_recovery_control_r[`PFP_FC_PIN_INT];
   assign irq_cmpa = comparator_flag & cmpa_seen_r &
                     fault_recovery_control_r[`PFP_FC_CMPA_INT];
   assign irq_cmpb = comparator_flag & cmpb_seen_r &
                     fault_recovery_control_r[`PFP_FC_CMPB_INT];
   assign fault_irq = irq_pin | irq_cmpa | irq_cmpb |
                      (cmp_event_r & comparator_flag &
                       (fault_recovery_control_r[`PFP_FC_CMPA_INT] |
                        fault_recovery_control_r[`PFP_FC_CMPB_INT]));

   // read port, data one cycle after strobe
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         reg_rdata <= `PFP_BYTE_ZERO;
      else if (reg_rd)
      begin
         if (sel_mask)
            reg_rdata <= fault_source_mask_r;
         else if (sel_stat)
            reg_rdata <= fault_status_flags;
         else if (sel_ctl)
            reg_rdata <= fault_recovery_control_r;
         else
            reg_rdata <= `PFP_BYTE_ZERO;
      end
      else
         reg_rdata <= `PFP_BYTE_ZERO;
   end

endmodule // pfp_fault_protect

`default_nettype wire

// ### verification/pfp_src_model.sv
`timescale 1ns/1ps
`default_nettype none

// fault pins, comparators and debug logic; slow adds one cycle of lag
module pfp_src_model
(
   input  wire       clk,
   input  wire [4:0] src_req,
   input  wire       slow,
   output reg  [4:0] src_lvl
);
   reg [4:0] req_d_r;
   initial src_lvl = 5'h00;
   always @(posedge clk)
   begin
      req_d_r <= src_req;
      src_lvl <= slow ? req_d_r : src_req;
   end
endmodule // pfp_src_model
`default_nettype wire

// ### verification/pfp_fault_protect_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "pfp_regs.vh"

module pfp_fp_sva
(
   input wire                   clk,
   input wire                   rst,
   input wire [`PFP_ADDR_W-1:0] reg_addr,
   input wire [7:0]             reg_wdata,
   input wire                   reg_wr,
   input wire                   reg_rd,
   input wire [7:0]             reg_rdata,
   input wire                   modulator_enable,
   input wire                   period_end,
   input wire                   fault_pin,
   input wire                   second_fault_in,
   input wire                   comparator_a,
   input wire                   comparator_b,
   input wire                   debug_mode,
   input wire [`PFP_NOUT-1:0]   pwm_in,
   input wire [`PFP_NOUT-1:0]   off_state,
   input wire [`PFP_NOUT-1:0]   pwm_out,
   input wire                   pwm_owned,
   input wire                   fault_active,
   input wire                   reload_event,
   input wire                   comparator_exception
);
   reg  [7:0] mask_r;
   wire [3:0] live;
   // shadow of the mask, only settable while unlocked
   always @(posedge clk or posedge rst)
      if (rst)
         mask_r <= 8'h00;
      else if (reg_wr && !modulator_enable && reg_addr == `PFP_OFS_MASK)
         mask_r <= mask_r | (reg_wdata & `PFP_FM_WMASK);
   assign live = {debug_mode & ~mask_r[5], second_fault_in & ~mask_r[2],
                  (comparator_a | comparator_b) & ~mask_r[1],
                  fault_pin & ~mask_r[0]};
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   AST_RDATA_IDLE: assert property (
      reg_rdata != 8'h00 |-> $past(reg_rd)) else $error("stray read data");
   AST_OFF_STATE: assert property (
      fault_active |=> pwm_out == $past(off_state))
      else $error("outputs not forced off");
   AST_PASS_THRU: assert property (
      pwm_owned |=> pwm_out == $past(pwm_in)) else $error("outputs not passed");
   AST_OWN_BLOCKED: assert property (
      fault_active |-> !pwm_owned) else $error("owned during fault");
   AST_CMP_EXC: assert property (
      comparator_exception == (comparator_a | comparator_b))
      else $error("comparator exception wrong");
   AST_FAULT_RAISED: assert property (
      |live |-> fault_active) else $error("unmasked source ignored");
   AST_FAULT_CAUSE: assert property (
      fault_active |-> |live) else $error("fault without source");
   AST_RELOAD_AT_END: assert property (
      reload_event |-> period_end) else $error("reload off period end");
   AST_RELEASE_EDGE: assert property (
      $rose(pwm_owned) |-> $past(period_end))
      else $error("release off period end");
endmodule // pfp_fp_sva

bind pfp_fault_protect pfp_fp_sva u_sva (.*);
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pfp_regs.vh"

module tb_top;
   reg                   clk, rst, reg_wr, reg_rd, en, pe, slow;
   reg [`PFP_ADDR_W-1:0] addr;
   reg [7:0]             wd;
   reg [1:0]             rate;
   reg [4:0]             req;
   reg [5:0]             pin, off;
   reg [31:0]            rnd;
   wire [7:0]            rdata;
   wire [4:0]            src;
   wire [5:0]            pout;
   wire                  owned, fact, rld, irq, cexc;
   integer               err_total, total_checks, cyc, n, rcount;
   integer               m_mask, m_stat, m_ctl, m_cnt, exp_rd, dbg_d;
   integer               m_trip, m_swp, m_out;
   wire m_rld = pe && en && m_cnt == (32'd1 << rate) - 1;
   wire m_fact = |({src[4], src[1], src[2] | src[3], src[0]} &
                   ~{m_mask[5], m_mask[2], m_mask[1], m_mask[0]});
   wire m_sw = (src[4] & !m_mask[5] & m_ctl[6]) |
               ((src[2] | src[3]) & !m_mask[1] & (m_ctl[2] | m_ctl[4])) |
               ((src[0] & !m_mask[0] | src[1] & !m_mask[2]) & m_ctl[0]);
   wire m_own = !m_fact && !m_trip;

   pfp_fault_protect uut (.clk(clk), .rst(rst), .reg_addr(addr),
      .reg_wdata(wd), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
      .modulator_enable(en), .reload_rate_select(rate), .period_end(pe),
      .fault_pin(src[0]), .second_fault_in(src[1]), .comparator_a(src[2]),
      .comparator_b(src[3]), .debug_mode(src[4]), .pwm_in(pin),
      .off_state(off), .pwm_out(pout), .pwm_owned(owned),
      .fault_active(fact), .reload_event(rld), .fault_irq(irq),
      .comparator_exception(cexc));
   pfp_src_model u_src (.clk(clk), .src_req(req), .slow(slow),
      .src_lvl(src));

   // reference register model
   always @(posedge clk or posedge rst)
      if (rst)
      begin
         m_mask <= 0;
         m_stat <= 0;
         m_ctl <= 0;
         m_cnt <= 0;
         dbg_d <= 0;
         m_trip <= 0;
         m_swp <= 0;
         m_out <= 0;
      end
      else
      begin
         if (reg_wr && !en && addr == `PFP_OFS_MASK)
            m_mask <= m_mask | (wd & 8'h27);
         if (reg_wr && !en && addr == `PFP_OFS_CTL)
            m_ctl <= wd & 8'h7f;
         m_stat <= m_stat & ~(reg_wr && addr == `PFP_OFS_STAT ? wd &
            {2'b10, !src[4], 2'b0, !src[1], !(src[2] | src[3]), !src[0]} : 0)
            | {m_rld, 1'b0, src[4] & !dbg_d[0], 2'b0, src[1] & !m_mask[2],
               (src[2] | src[3]) & !m_mask[1], src[0] & !m_mask[0]};
         dbg_d <= src[4];
         if (pe && en)
            m_cnt <= m_rld ? 0 : m_cnt + 1;
         if (reg_rd)
            exp_rd <= addr == `PFP_OFS_MASK ? m_mask : addr == `PFP_OFS_STAT ?
                      m_stat : addr == `PFP_OFS_CTL ? m_ctl : 0;
         if (m_fact)
         begin
            m_trip <= 1;
            m_swp <= m_swp | m_sw;
         end
         else if (m_trip && (m_swp ? m_rld && !(m_stat & 8'h27) : pe))
         begin
            m_trip <= 0;
            m_swp <= 0;
         end
         m_out <= m_own ? pin : off;
      end

   task chk(input ok, input [8*16-1:0] msg);
   begin
      total_checks = total_checks + 1;
      if (!ok)
      begin
         err_total = err_total + 1;
         $display("[FAIL] %0t %0s", $time, msg);
      end
   end
   endtask

   task results;
   begin
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   end
   endtask

   task tick(input integer k);
      repeat (k) @(posedge clk);
   endtask

   task do_rst;
   begin
      rst <= 1'b1;
      tick(16);
      rst <= 1'b0;
      tick(1);
   end
   endtask

   task wr(input [`PFP_ADDR_W-1:0] a, input [7:0] d);
   begin
      addr <= a;
      wd <= d;
      reg_wr <= 1'b1;
      tick(1);
      reg_wr <= 1'b0;
      tick(1);
   end
   endtask

   task rd(input [`PFP_ADDR_W-1:0] a);
   begin
      addr <= a;
      reg_rd <= 1'b1;
      tick(1);
      reg_rd <= 1'b0;
      #1 chk(rdata === exp_rd[7:0], "read data");
      tick(1);
   end
   endtask

   task pend;
   begin
      pe <= 1'b1;
      tick(1);
      pe <= 1'b0;
      tick(1);
   end
   endtask

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk)
   begin
      rnd = $urandom;
      pin <= rnd[5:0];
      off <= rnd[11:6];
      cyc = cyc + 1;
      if (cyc == 20000)
      begin
         err_total = err_total + 1;
         results;
      end
   end

   always @(negedge clk)
      if (!rst)
      begin
         chk(rld === m_rld && fact === m_fact, "reload or fault");
         chk(owned === m_own && pout === m_out[5:0], "outputs");
         chk(cexc === (src[2] | src[3]), "exception");
         if (rld)
            rcount = rcount + 1;
      end

   initial
   begin
      {rst, reg_wr, reg_rd, en, pe, slow} = 6'h20;
      {addr, wd, rate, req, pin, off} = 0;
      {err_total, total_checks, cyc, rcount} = 0;
      rnd = $urandom(32'h55fa);
      do_rst;
      rd(`PFP_OFS_MASK);
      rd(`PFP_OFS_STAT);
      rd(`PFP_OFS_CTL);
      rd(24'hffe386);
      en <= 1'b1;
      wr(`PFP_OFS_MASK, 8'h01);
      wr(`PFP_OFS_CTL, 8'h41);
      en <= 1'b0;
      rd(`PFP_OFS_MASK);
      rd(`PFP_OFS_CTL);
      wr(`PFP_OFS_CTL, 8'h7f);
      rd(`PFP_OFS_CTL);
      wr(`PFP_OFS_CTL, 8'h00);
      wr(`PFP_OFS_MASK, 8'h01);
      wr(`PFP_OFS_MASK, 8'h00);
      wr(`PFP_OFS_MASK, 8'h24);
      rd(`PFP_OFS_MASK);
      req <= 5'h13;
      tick(3);
      #1 chk(fact === 1'b0, "masked fault");
      rd(`PFP_OFS_STAT);
      req <= 5'h00;
      do_rst;
      slow <= 1'b1;
      req <= 5'h1f;
      tick(4);
      rd(`PFP_OFS_STAT);
      #1 chk(irq === 1'b0, "irq disabled");
      wr(`PFP_OFS_STAT, 8'h07);
      rd(`PFP_OFS_STAT);
      req <= 5'h00;
      tick(4);
      wr(`PFP_OFS_STAT, 8'h00);
      rd(`PFP_OFS_STAT);
      wr(`PFP_OFS_STAT, 8'h27);
      rd(`PFP_OFS_STAT);
      slow <= 1'b0;
      for (n = 0; n < 4; n = n + 1)
      begin
         do_rst;
         rate <= n[1:0];
         en <= 1'b1;
         rcount = 0;
         repeat (8) pend;
         chk(rcount == (8 >> n), "reload count");
         rd(`PFP_OFS_STAT);
      end
      rate <= 2'h0;
      req <= 5'h01;
      tick(3);
      #1 chk(owned === 1'b0, "not tripped");
      req <= 5'h00;
      tick(3);
      #1 chk(owned === 1'b0, "early release");
      pend;
      #1 chk(owned === 1'b1, "no auto release");
      en <= 1'b0;
      wr(`PFP_OFS_CTL, 8'h03);
      en <= 1'b1;
      req <= 5'h01;
      tick(3);
      #1 chk(irq === 1'b1, "no irq");
      req <= 5'h00;
      tick(3);
      pend;
      #1 chk(owned === 1'b0, "released early");
      wr(`PFP_OFS_STAT, 8'h01);
      pend;
      #1 chk(owned === 1'b1, "not released");
      en <= 1'b0;
      wr(`PFP_OFS_CTL, 8'h64);
      en <= 1'b1;
      req <= 5'h18;
      tick(3);
      #1 chk(irq === 1'b1, "no cmp irq");
      req <= 5'h00;
      tick(3);
      wr(`PFP_OFS_STAT, 8'h22);
      pend;
      #1 chk(owned === 1'b1, "sw release");
      results;
   end
endmodule // tb_top
`default_nettype wire
